// ==== shared/port_pkg.sv ====
// shared constants for the port direction and pull control block
package port_pkg;
   // ==========================================================
   // register map (word offsets on a byte-addressed bus)
   localparam logic [3:0] OFF_DATA = 4'h0;
   localparam logic [3:0] OFF_INPUT = 4'h4;
   localparam logic [3:0] OFF_DIR = 4'h8;
   localparam logic [3:0] OFF_PULL_EN = 4'hC;
   // ==========================================================
   // reset values
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_PULL_EN = 8'hFF;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_POLARITY = 8'h00;
   // ==========================================================
   // pin positions with shared functions
   localparam int PIN_SEG_LO = 4;
   localparam int PIN_SEG_HI = 7;
   localparam int PIN_I2C_SDA = 5;
   localparam int PIN_I2C_SCL = 6;
   localparam int PIN_TIM2_LO = 2;
   localparam int PIN_TIM2_HI = 3;
   localparam int PIN_TX = 1;
   localparam int PIN_RX = 0;
   // ==========================================================
   // input synchroniser depth, which is why reads lag direction changes
   localparam int SYNC_STAGES = 2;
endpackage

// ==== shared/pad_ctl_if.sv ====
// carrier between the register file and the pad control logic
`timescale 1ns/1ns
`default_nettype none
interface pad_ctl_if #(parameter int N = 8);
   logic [N-1:0] dir;
   logic [N-1:0] pull_en;
   logic [N-1:0] polarity;
   logic [N-1:0] seg_en;
   logic [N-1:0] i2c_od;
   logic [N-1:0] force_out;
   logic [N-1:0] force_in;
   logic [N-1:0] is_out;
   logic [N-1:0] in_dis;
   logic [N-1:0] pull_act;
   modport ctl (output dir, pull_en, polarity, seg_en, i2c_od, force_out, force_in,
      input is_out, in_dis, pull_act);
   modport pad (input dir, pull_en, polarity, seg_en, i2c_od, force_out, force_in,
      output is_out, in_dis, pull_act);
endinterface
`default_nettype wire

// ==== hdl/pad_resolve.sv ====
// per-pin resolution of effective direction and pull activity
`timescale 1ns/1ns
`default_nettype none
module pad_resolve #(parameter int N = 8) (
   pad_ctl_if.pad p
);
   // ==========================================================
   // pin resolution
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_pin
         // segment disable beats every other source, then the forcing terms
         assign p.is_out[g] = !p.seg_en[g] && (p.force_out[g] || p.i2c_od[g] ||
            (!p.force_in[g] && p.dir[g]));
         assign p.in_dis[g] = p.seg_en[g];
         // pulls only on a live input, never on a forced or software output
         assign p.pull_act[g] = p.pull_en[g] && !p.is_out[g] && !p.seg_en[g];
      end
   endgenerate
endmodule
`default_nettype wire

// ==== hdl/port_pin_direction_pull_control.sv ====
// eight-pin port direction and pull control with a classic wishbone slave
//
// Overview of operation
// - direction bit 1 makes pin output, 0 input, unless overridden
// - segment driver enabled disables input and output on pins 7..4
// - pins 6,5 become open-drain outputs when routed i2c enabled, no segment
// - pins 3,2 forced output when routed second timer compare enabled
// - pin 1 output on first timer compare, else on network transmit
// - pin 0 output on timer compare, else input on network receive
// - data and input reads may lag a direction write by two clocks
// - pull enable bit 1 turns pull on, 0 off, on input pins
// - pull enable ignored while pin is an output, any source
// - every pull enable bit is set by reset
// - direction and pull enable registers read and write at any time
// - data read gives stored bit when direction 1, else pin input
// - polarity 1 selects pull-down, 0 selects pull-up
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module port_pin_direction_pull_control #(
   parameter int N = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // routed peripheral enables and pull polarity select
   input wire logic seg_en_i,
   input wire logic i2c_en_i,
   input wire logic tim_second_oc_i,
   input wire logic [1:0] tim_first_oc_i,
   input wire logic tx_en_i,
   input wire logic rx_en_i,
   input wire logic [N-1:0] pull_polarity_i,
   // pads
   input wire logic [N-1:0] pad_in_i,
   output logic [N-1:0] pad_out_o,
   output logic [N-1:0] pad_oe_n_o,
   output logic [N-1:0] pad_in_dis_o,
   output logic [N-1:0] pad_od_o,
   output logic [N-1:0] pad_pull_up_o,
   output logic [N-1:0] pad_pull_down_o
);
   // ==========================================================
   // elaboration check: the pin mapping serves exactly eight pins
   if (N != 8) begin : g_bad_width
      $error("pin mapping serves exactly eight pins");
   end

   pad_ctl_if #(.N(N)) c ();
   pad_resolve #(.N(N)) u_res (.p(c));

   logic [N-1:0] dir_r;
   logic [N-1:0] pull_en_r;
   logic [N-1:0] data_r;
   logic [N-1:0] sync1_r;
   logic [N-1:0] sync2_r;
   logic [N-1:0] rdat_nxt;
   logic wr;
   logic rd_go;

   // ==========================================================
   // override terms per pin
   always_comb begin
      c.seg_en = '0;
      c.i2c_od = '0;
      c.force_out = '0;
      c.force_in = '0;
      for (int i = port_pkg::PIN_SEG_LO; i <= port_pkg::PIN_SEG_HI; i++) begin
         c.seg_en[i] = seg_en_i;
      end
      c.i2c_od[port_pkg::PIN_I2C_SDA] = i2c_en_i;
      c.i2c_od[port_pkg::PIN_I2C_SCL] = i2c_en_i;
      c.force_out[port_pkg::PIN_TIM2_LO] = tim_second_oc_i;
      c.force_out[port_pkg::PIN_TIM2_HI] = tim_second_oc_i;
      c.force_out[port_pkg::PIN_TX] = tim_first_oc_i[1] || tx_en_i;
      c.force_out[port_pkg::PIN_RX] = tim_first_oc_i[0];
      // receive only wins when no timer compare claims the pin
      c.force_in[port_pkg::PIN_RX] = !tim_first_oc_i[0] && rx_en_i;
   end

   assign c.dir = dir_r;
   assign c.pull_en = pull_en_r;
   assign c.polarity = pull_polarity_i;

   // ==========================================================
   // bus decode: one wait state, ack drops the cycle after it was given
   assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
   assign rd_go = cyc_i && stb_i && !ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= rd_go;
      end
   end

   // direction register, software value only; overrides never write here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_r <= port_pkg::RST_DIR;
      end else if (wr && adr_i == port_pkg::OFF_DIR) begin
         dir_r <= dat_i[N-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pull_en_r <= port_pkg::RST_PULL_EN;
      end else if (wr && adr_i == port_pkg::OFF_PULL_EN) begin
         pull_en_r <= dat_i[N-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_r <= port_pkg::RST_DATA;
      end else if (wr && adr_i == port_pkg::OFF_DATA) begin
         data_r <= dat_i[N-1:0];
      end
   end

   // ==========================================================
   // two-stage pin synchroniser; this is the source of the read lag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= pad_in_i;
         sync2_r <= sync1_r;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rdat_nxt = '0;
      case (adr_i)
         port_pkg::OFF_DATA: begin
            rdat_nxt = (dir_r & data_r) | (~dir_r & sync2_r);
         end
         port_pkg::OFF_INPUT: begin
            rdat_nxt = sync2_r;
         end
         port_pkg::OFF_DIR: begin
            rdat_nxt = dir_r;
         end
         port_pkg::OFF_PULL_EN: begin
            rdat_nxt = pull_en_r;
         end
         default: begin
            rdat_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd_go && !we_i) begin
         dat_o <= {{(32-N){1'b0}}, rdat_nxt};
      end
   end

   // ==========================================================
   // registered pad drive
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pad_out_o <= '0;
         pad_oe_n_o <= '1;
         pad_in_dis_o <= '0;
         pad_od_o <= '0;
         pad_pull_up_o <= '0;
         pad_pull_down_o <= '0;
      end else begin
         pad_out_o <= data_r;
         pad_oe_n_o <= ~c.is_out;
         pad_in_dis_o <= c.in_dis;
         pad_od_o <= c.i2c_od & ~c.seg_en;
         pad_pull_up_o <= c.pull_act & ~c.polarity;
         pad_pull_down_o <= c.pull_act & c.polarity;
      end
   end

   // ==========================================================
   // checks
   sequence s_dir_write;
      wr && adr_i == port_pkg::OFF_DIR;
   endsequence

   property p_dir_out;
      @(posedge clk_i) disable iff (rst_i)
      (!seg_en_i && !i2c_en_i && !tim_second_oc_i && tim_first_oc_i == 2'h0 &&
         !tx_en_i && !rx_en_i) |=> (pad_oe_n_o == ~$past(dir_r));
   endproperty
   a_dir_out: assert property (p_dir_out) else $error("direction not on pad");

   property p_seg;
      @(posedge clk_i) disable iff (rst_i)
      seg_en_i |=> (pad_oe_n_o[7:4] == 4'hF && pad_in_dis_o[7:4] == 4'hF);
   endproperty
   a_seg: assert property (p_seg) else $error("segment pins not disabled");

   property p_i2c;
      @(posedge clk_i) disable iff (rst_i)
      (i2c_en_i && !seg_en_i) |=> (pad_oe_n_o[6:5] == 2'h0 && pad_od_o[6:5] == 2'h3);
   endproperty
   a_i2c: assert property (p_i2c) else $error("i2c pins not open drain");

   property p_tim2;
      @(posedge clk_i) disable iff (rst_i)
      tim_second_oc_i |=> pad_oe_n_o[3:2] == 2'h0;
   endproperty
   a_tim2: assert property (p_tim2) else $error("timer pins not output");

   property p_tx;
      @(posedge clk_i) disable iff (rst_i)
      (tim_first_oc_i[1] || tx_en_i) |=> !pad_oe_n_o[1];
   endproperty
   a_tx: assert property (p_tx) else $error("pin 1 not output");

   property p_rx;
      @(posedge clk_i) disable iff (rst_i)
      (!tim_first_oc_i[0] && rx_en_i) |=> pad_oe_n_o[0];
   endproperty
   a_rx: assert property (p_rx) else $error("pin 0 not input");

   property p_pull_out;
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> ((~pad_oe_n_o & (pad_pull_up_o | pad_pull_down_o)) == 8'h00);
   endproperty
   a_pull_out: assert property (p_pull_out) else $error("pull on output pin");

   property p_pull_rst;
      @(posedge clk_i) $fell(rst_i) |-> pull_en_r == 8'hFF;
   endproperty
   a_pull_rst: assert property (p_pull_rst) else $error("pull enables not set");

   property p_dir_keep;
      @(posedge clk_i) disable iff (rst_i)
      s_dir_write |=> dir_r == $past(dat_i[N-1:0]) ##1 $stable(dir_r);
   endproperty
   a_dir_keep: assert property (p_dir_keep) else $error("direction not kept");

   property p_sync;
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |-> ##2 sync2_r == $past(pad_in_i, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("input lag not two");

   // bus handshake in two steps: request taken, then a one-cycle answer
   sequence s_bus_req;
      cyc_i && stb_i && !ack_o;
   endsequence

   sequence s_bus_ack;
      ack_o ##1 !ack_o;
   endsequence

   property p_bus;
      @(posedge clk_i) disable iff (rst_i)
      s_bus_req |=> s_bus_ack;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer not a single pulse");

   property p_data_rd;
      @(posedge clk_i) disable iff (rst_i)
      (rd_go && !we_i && adr_i == port_pkg::OFF_DATA) |=>
         dat_o[N-1:0] == (($past(dir_r) & $past(data_r)) | (~$past(dir_r) & $past(sync2_r)));
   endproperty
   a_data_rd: assert property (p_data_rd) else $error("data read source wrong");

   property p_in_rd;
      @(posedge clk_i) disable iff (rst_i)
      (rd_go && !we_i && adr_i == port_pkg::OFF_INPUT) |=> dat_o[N-1:0] == $past(sync2_r);
   endproperty
   a_in_rd: assert property (p_in_rd) else $error("input read not synchronised");

   property p_pull_wr;
      @(posedge clk_i) disable iff (rst_i)
      (wr && adr_i == port_pkg::OFF_PULL_EN) |=> pull_en_r == $past(dat_i[N-1:0]);
   endproperty
   a_pull_wr: assert property (p_pull_wr) else $error("pull enable write lost");

   // a write without the low byte lane leaves every register alone
   property p_sel_keep;
      @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && we_i && !ack_o && !sel_i[0]) |=>
         ($stable(dir_r) && $stable(pull_en_r) && $stable(data_r));
   endproperty
   a_sel_keep: assert property (p_sel_keep) else $error("masked write changed state");

   // pulls follow the enable bit on every live input pin, by polarity
   property p_pull_up;
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> pad_pull_up_o ==
         ($past(pull_en_r) & pad_oe_n_o & ~pad_in_dis_o & ~$past(pull_polarity_i));
   endproperty
   a_pull_up: assert property (p_pull_up) else $error("pull-up not as enabled");

   property p_pull_dn;
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> pad_pull_down_o ==
         ($past(pull_en_r) & pad_oe_n_o & ~pad_in_dis_o & $past(pull_polarity_i));
   endproperty
   a_pull_dn: assert property (p_pull_dn) else $error("pull-down not as selected");

endmodule
`default_nettype wire

// ==== verif/pin_partner.sv ====
// pin-side model: device drive, outside drive, pulls, else a wandering level
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
   input wire logic clk_i,
   input wire logic [7:0] out_i,
   input wire logic [7:0] oe_n_i,
   input wire logic [7:0] od_i,
   input wire logic [7:0] up_i,
   input wire logic [7:0] dn_i,
   input wire logic [7:0] ext_i,
   input wire logic [7:0] ext_drv_i,
   output logic [7:0] pin_o
);
   logic [7:0] float_r;
   // an undriven pin toggles so it never passes for a settled level
   always @(posedge clk_i) begin
      float_r <= (float_r === 8'h00) ? 8'hFF : 8'h00;
   end
   // open drain never drives a one; device drive beats the outside world
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!oe_n_i[i] && !(od_i[i] && out_i[i])) pin_o[i] = out_i[i];
         else if (ext_drv_i[i]) pin_o[i] = ext_i[i];
         else if (up_i[i]) pin_o[i] = 1'b1;
         else if (dn_i[i]) pin_o[i] = 1'b0;
         else pin_o[i] = float_r[i];
      end
   end
endmodule
`default_nettype wire

// ==== verif/port_pin_direction_pull_control_test.sv ====
// self-checking bench for the port direction and pull control block
`timescale 1ns/1ns
`default_nettype none
module port_pin_direction_pull_control_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, seg, i2c, t2, tx, rx;
   logic [3:0] sel, bsel;
   logic [1:0] t1;
   logic [3:0] adr;
   logic [31:0] dat_w, dat_r, q;
   logic [7:0] pol, pin, ext, ext_drv, dir, pen, dat;
   logic [7:0] p_out, p_oe_n, p_dis, p_od, p_up, p_dn;
   logic [6:0] rows [0:9] = '{7'h40, 7'h60, 7'h20, 7'h10, 7'h08, 7'h02, 7'h04, 7'h01, 7'h05, 7'h7F};
   int bad_count = 0;
   int samples_checked = 0;
   always #20 clk_i = ~clk_i;
   port_pin_direction_pull_control u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r),
      .ack_o(ack), .seg_en_i(seg), .i2c_en_i(i2c), .tim_second_oc_i(t2),
      .tim_first_oc_i(t1), .tx_en_i(tx), .rx_en_i(rx), .pull_polarity_i(pol),
      .pad_in_i(pin), .pad_out_o(p_out), .pad_oe_n_o(p_oe_n), .pad_in_dis_o(p_dis),
      .pad_od_o(p_od), .pad_pull_up_o(p_up), .pad_pull_down_o(p_dn));
   pin_partner u_pins (.clk_i(clk_i), .out_i(p_out), .oe_n_i(p_oe_n), .od_i(p_od),
      .up_i(p_up), .dn_i(p_dn), .ext_i(ext), .ext_drv_i(ext_drv), .pin_o(pin));
   // ==========================================================
   // checking and bus access
   task automatic report_and_stop;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle; read data is taken at the edge that sees ack
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= bsel;
      adr <= a;
      dat_w <= {24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         bad_count++;
         $display("MISMATCH ack expected 1 seen %b", ack);
         report_and_stop();
      end
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk("read data", e, q[7:0]);
   endtask
   // pad outputs lag one clock, so look two edges after the cause
   task automatic pads;
      logic [7:0] o, di;
      repeat (2) @(posedge clk_i);
      // look at the settled outputs, away from the launching edge
      @(negedge clk_i);
      o = dir;
      if (t2) o[3:2] = 2'b11;
      if (t1[1] || tx) o[1] = 1'b1;
      if (t1[0]) o[0] = 1'b1;
      else if (rx) o[0] = 1'b0;
      if (seg) o[7:4] = 4'h0;
      else if (i2c) o[6:5] = 2'b11;
      di = seg ? 8'hF0 : 8'h00;
      chk("oe_n", ~o, p_oe_n);
      chk("in_dis", di, p_dis);
      chk("od", (i2c && !seg) ? 8'h60 : 8'h00, p_od);
      chk("pull_up", pen & ~o & ~di & ~pol, p_up);
      chk("pull_down", pen & ~o & ~di & pol, p_dn);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {cyc, stb, we, seg, i2c, t2, tx, rx} = 8'h00;
      t1 = 2'b00;
      sel = 4'h0;
      bsel = 4'hF;
      adr = 4'h0;
      dat_w = 32'h00000000;
      pol = 8'h00;
      ext = 8'h00;
      ext_drv = 8'h00;
      dir = 8'h00;
      pen = 8'hFF;
      dat = 8'h00;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(port_pkg::OFF_DIR, dir);
      rd(port_pkg::OFF_PULL_EN, pen);
      pads();
      rd(4'h2, 8'h00);
      pen = 8'h3C;
      wb(1'b1, port_pkg::OFF_PULL_EN, pen);
      rd(port_pkg::OFF_PULL_EN, pen);
      // a write without the low byte lane must leave the register alone
      bsel = 4'h0;
      wb(1'b1, port_pkg::OFF_PULL_EN, 8'h00);
      bsel = 4'hF;
      rd(port_pkg::OFF_PULL_EN, pen);
      dat = 8'hC3;
      wb(1'b1, port_pkg::OFF_DATA, dat);
      pol <= 8'hF0;
      ext <= 8'h5A;
      ext_drv <= 8'hFF;
      // flip direction and see reads follow once the sync stages settle
      for (int k = 0; k < 2; k++) begin
         dir = k ? 8'h5A : 8'hA5;
         wb(1'b1, port_pkg::OFF_DIR, dir);
         rd(port_pkg::OFF_DIR, dir);
         pads();
         repeat (2) @(posedge clk_i);
         rd(port_pkg::OFF_DATA, (dat & dir) | (8'h5A & ~dir));
         rd(port_pkg::OFF_INPUT, (dat & dir) | (8'h5A & ~dir));
         chk("pad_out", dat, p_out);
      end
      ext_drv <= 8'h00;
      pen = 8'hFF;
      wb(1'b1, port_pkg::OFF_PULL_EN, pen);
      // every override alone and in priority pairs, both direction settings
      for (int d = 0; d < 2; d++) begin
         dir = d ? 8'hFF : 8'h00;
         wb(1'b1, port_pkg::OFF_DIR, dir);
         foreach (rows[r]) begin
            @(posedge clk_i);
            {seg, i2c, t2, t1, tx, rx} <= rows[r];
            pads();
            rd(port_pkg::OFF_DIR, dir);
         end
      end
      // a second reset in mid-run sets every pull enable again
      wb(1'b1, port_pkg::OFF_PULL_EN, 8'h00);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(port_pkg::OFF_PULL_EN, 8'hFF);
      rd(port_pkg::OFF_DIR, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
